// File: rtl/tsoi_ctrl.v
// Transmit section overhead insertion control: AXI4-Lite registers and
// the per-slot byte selection of the outgoing overhead stream.
// Assumes upstream supplies one slot per beat, tagged with a slot code,
// with generated parity and pointer bytes already on in_gen_byte.
// Function
// - AIS force bit 7 inserts pointer-level AIS toward the network.
// - With M1 from hardware, bit 6 picks error count or zero REI.
// - National bytes not serial: bit 5 picks AAH or software value.
// - With K2 from hardware, bit 4 picks generated RDI or register K2.
// - B2 invert field: 0X none, 10 every frame, 11 one frame.
// - B1 invert field uses the same coding as B2.
// - RDI controls act only with hardware K2 and hardware RDI bits.
// - Excess-parity enable sends RDI 110 while excess status active.
// - Force bit sends RDI 110 whatever the excess status.
// - Trace byte source: 00 software, 01 serial, 1X received.
// - E1 from orderwire input when 0, received byte when 1.
// - F1 from user channel input when 0, received byte when 1.
// - D1-D3 from regenerator data input when 0, received when 1.
// - D4-D12 from multiplex data input when 0, received when 1.
// - E2 from multiplex orderwire input when 0, received when 1.
// - M1 from internal REI or serial; regenerator passes received M1.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "tsoi_defines.vh"
module tsoi_ctrl #(
    parameter ADDR_W = 12,
    parameter BUF_DEPTH = 2
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire in_valid,
    output wire in_ready,
    input wire [3:0] in_slot,
    input wire in_frame_start,
    input wire [7:0] in_gen_byte,
    input wire [7:0] in_rx_byte,
    input wire [7:0] overhead_serial_input,
    input wire [7:0] regen_orderwire_input,
    input wire [7:0] user_channel_input,
    input wire [7:0] regen_data_channel_input,
    input wire [7:0] mux_data_channel_input,
    input wire [7:0] mux_orderwire_input,
    input wire [7:0] ms_error_count,
    input wire excess_ms_parity_status,
    output wire out_valid,
    input wire out_ready,
    output wire [3:0] out_slot,
    output wire out_frame_start,
    output wire [7:0] out_byte
);
    // Inversion applies for code 10, or code 11 within the chosen frame
    function inv_apply;
        input [1:0] code;
        input once;
        begin
            inv_apply = code[1] & (~code[0] | once);
        end
    endfunction

    // Word index of a byte address
    function [9:0] word_idx;
        input [ADDR_W-1:0] addr;
        begin
            word_idx = addr[ADDR_W-1:2];
        end
    endfunction

    // Register file
    reg [7:0] op1_reg, op2_reg, src1_reg, src2_reg;
    reg [7:0] k2_reg, cfg_reg, nat_reg, trace_reg;
    // Write channel holding
    reg aw_hold_reg, w_hold_reg, wstrb0_reg, bvalid_reg;
    reg [ADDR_W-1:0] awaddr_reg;
    reg [7:0] wdata_reg;
    reg [1:0] bresp_reg;
    // Read channel
    reg rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;
    // Single-frame parity inversion state
    reg b1_pend_reg, b1_pend_next, b2_pend_reg, b2_pend_next;
    reg b1_frame_reg, b2_frame_reg, rdi_active_reg;
    // Combinational
    reg [7:0] sel_byte;
    reg [2:0] rdi_bits;
    reg rd_hit;
    reg [7:0] rd_byte;
    wire wr_fire, wr_en, wr_hit, beat, frame_beat;
    wire b1_once, b2_once, regen, k2_hw, rdi_ctrl_on, rdi_insert;
    wire [9:0] wr_idx, rd_idx;
    wire [1:0] b1_code, b2_code;

    // Bus handshakes; a channel waits while its own word is held
    assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign wr_idx = word_idx(awaddr_reg);
    assign rd_idx = word_idx(s_axi_araddr);
    assign wr_en = wr_fire & wstrb0_reg;
    // Status is read-only, so a write to it is refused like a hole
    assign wr_hit = (wr_idx == `TSOI_IDX_OP1) || (wr_idx == `TSOI_IDX_OP2) ||
        (wr_idx == `TSOI_IDX_SRC1) || (wr_idx == `TSOI_IDX_SRC2) ||
        (wr_idx == `TSOI_IDX_K2) || (wr_idx == `TSOI_IDX_CFG) ||
        (wr_idx == `TSOI_IDX_NAT) || (wr_idx == `TSOI_IDX_TRACE);

    // Address and data are taken in either order and held until both are in
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= {ADDR_W{1'b0}};
            wdata_reg <= `TSOI_RST_BYTE;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `TSOI_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? `TSOI_RESP_OKAY : `TSOI_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Register writes; only the low byte lane carries data
    always @(posedge aclk) begin
        if (!aresetn) begin
            op1_reg <= `TSOI_RST_BYTE;
            op2_reg <= `TSOI_RST_BYTE;
            src1_reg <= `TSOI_RST_BYTE;
            src2_reg <= `TSOI_RST_BYTE;
            k2_reg <= `TSOI_RST_BYTE;
            cfg_reg <= `TSOI_RST_BYTE;
            nat_reg <= `TSOI_RST_BYTE;
            trace_reg <= `TSOI_RST_BYTE;
        end else if (wr_en) begin
            case (wr_idx)
                `TSOI_IDX_OP1: op1_reg <= wdata_reg;
                `TSOI_IDX_OP2: op2_reg <= wdata_reg & 8'h06;
                `TSOI_IDX_SRC1: src1_reg <= wdata_reg;
                `TSOI_IDX_SRC2: src2_reg <= wdata_reg & 8'h02;
                `TSOI_IDX_K2: k2_reg <= wdata_reg;
                `TSOI_IDX_CFG: cfg_reg <= wdata_reg & 8'h03;
                `TSOI_IDX_NAT: nat_reg <= wdata_reg;
                `TSOI_IDX_TRACE: trace_reg <= wdata_reg;
                default: op1_reg <= op1_reg;
            endcase
        end
    end

    // Read decode; reserved bits are zero because the stores mask them
    always @* begin
        rd_hit = 1'b1;
        rd_byte = `TSOI_RST_BYTE;
        case (rd_idx)
            `TSOI_IDX_OP1: rd_byte = op1_reg;
            `TSOI_IDX_OP2: rd_byte = op2_reg;
            `TSOI_IDX_SRC1: rd_byte = src1_reg;
            `TSOI_IDX_SRC2: rd_byte = src2_reg;
            `TSOI_IDX_K2: rd_byte = k2_reg;
            `TSOI_IDX_CFG: rd_byte = cfg_reg;
            `TSOI_IDX_NAT: rd_byte = nat_reg;
            `TSOI_IDX_TRACE: rd_byte = trace_reg;
            `TSOI_IDX_STAT: rd_byte = {4'h0, rdi_active_reg, b2_pend_reg,
                b1_pend_reg, excess_ms_parity_status};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read answer lands one edge after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `TSOI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, rd_byte};
            rresp_reg <= rd_hit ? `TSOI_RESP_OKAY : `TSOI_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Stream side decode
    assign beat = in_valid & in_ready;
    assign frame_beat = beat & in_frame_start;
    assign regen = cfg_reg[`TSOI_CFG_REGEN];
    assign b1_code = op1_reg[1:0];
    assign b2_code = op1_reg[3:2];
    assign k2_hw = ~src2_reg[`TSOI_SRC2_K2];
    assign rdi_ctrl_on = k2_hw & ~op1_reg[`TSOI_OP1_RDI];
    assign rdi_insert = rdi_ctrl_on & (op2_reg[`TSOI_OP2_FRC] |
        (op2_reg[`TSOI_OP2_EXC] & excess_ms_parity_status));
    // Frame picked for a single inversion is the one that starts now
    assign b1_once = frame_beat ? b1_pend_reg : b1_frame_reg;
    assign b2_once = frame_beat ? b2_pend_reg : b2_frame_reg;

    // A write of code 11 arms; the next frame start consumes it.
    // Set wins over consume so a write racing a frame start is kept.
    always @* begin
        b1_pend_next = b1_pend_reg & ~frame_beat;
        b2_pend_next = b2_pend_reg & ~frame_beat;
        if (wr_en && wr_idx == `TSOI_IDX_OP1) begin
            if (wdata_reg[1:0] == 2'b11) begin
                b1_pend_next = 1'b1;
            end
            if (wdata_reg[3:2] == 2'b11) begin
                b2_pend_next = 1'b1;
            end
        end
    end

    // Pending and per-frame inversion flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            b1_pend_reg <= 1'b0;
            b2_pend_reg <= 1'b0;
            b1_frame_reg <= 1'b0;
            b2_frame_reg <= 1'b0;
            rdi_active_reg <= 1'b0;
        end else begin
            b1_pend_reg <= b1_pend_next;
            b2_pend_reg <= b2_pend_next;
            if (frame_beat) begin
                b1_frame_reg <= b1_pend_reg;
                b2_frame_reg <= b2_pend_reg;
            end
            rdi_active_reg <= rdi_insert;
        end
    end

    // Generated RDI bits of K2
    always @* begin
        rdi_bits = rdi_insert ? `TSOI_RDI_CODE : `TSOI_RDI_NONE;
    end

    // Per-slot source selection of the transmitted byte
    always @* begin
        sel_byte = in_gen_byte;
        case (in_slot)
            `TSOI_SLOT_J0: begin
                if (src1_reg[7]) begin
                    sel_byte = in_rx_byte;
                end else if (src1_reg[6]) begin
                    sel_byte = overhead_serial_input;
                end else begin
                    sel_byte = trace_reg;
                end
            end
            `TSOI_SLOT_E1: sel_byte = src1_reg[`TSOI_SRC1_E1] ? in_rx_byte :
                regen_orderwire_input;
            `TSOI_SLOT_F1: sel_byte = src1_reg[`TSOI_SRC1_F1] ? in_rx_byte :
                user_channel_input;
            `TSOI_SLOT_D13: sel_byte = src1_reg[`TSOI_SRC1_D13] ? in_rx_byte :
                regen_data_channel_input;
            `TSOI_SLOT_D412: sel_byte = src1_reg[`TSOI_SRC1_D412] ? in_rx_byte :
                mux_data_channel_input;
            `TSOI_SLOT_E2: sel_byte = src1_reg[`TSOI_SRC1_E2] ? in_rx_byte :
                mux_orderwire_input;
            `TSOI_SLOT_M1: begin
                if (regen) begin
                    sel_byte = in_rx_byte;
                end else if (src1_reg[`TSOI_SRC1_M1]) begin
                    sel_byte = overhead_serial_input;
                end else if (op1_reg[`TSOI_OP1_REI]) begin
                    sel_byte = `TSOI_RST_BYTE;
                end else begin
                    sel_byte = ms_error_count;
                end
            end
            `TSOI_SLOT_K2: begin
                // Regenerators pass K2 straight through
                if (regen) begin
                    sel_byte = in_rx_byte;
                end else if (!k2_hw) begin
                    sel_byte = overhead_serial_input;
                end else if (op1_reg[`TSOI_OP1_RDI]) begin
                    sel_byte = k2_reg;
                end else begin
                    sel_byte = {k2_reg[7:3], rdi_bits};
                end
            end
            `TSOI_SLOT_NAT: begin
                if (cfg_reg[`TSOI_CFG_NATSER]) begin
                    sel_byte = overhead_serial_input;
                end else if (op1_reg[`TSOI_OP1_NAT]) begin
                    sel_byte = nat_reg;
                end else begin
                    sel_byte = `TSOI_NAT_DEFAULT;
                end
            end
            `TSOI_SLOT_B1: sel_byte = inv_apply(b1_code, b1_once) ?
                ~in_gen_byte : in_gen_byte;
            `TSOI_SLOT_B2: sel_byte = inv_apply(b2_code, b2_once) ?
                ~in_gen_byte : in_gen_byte;
            // Only pointer and payload are hit; overhead stays live
            `TSOI_SLOT_PTR, `TSOI_SLOT_PAY: sel_byte =
                op1_reg[`TSOI_OP1_AIS] ? `TSOI_AIS_BYTE : in_gen_byte;
            default: sel_byte = in_gen_byte;
        endcase
    end

    // Two-entry buffer absorbs a receiver stall without dropping a beat;
    // its ready is the stream's ready, so the source stalls when full.
    tsoi_buffer #(
        .WIDTH(13),
        .DEPTH(BUF_DEPTH),
        .AW(1)
    ) u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data({in_frame_start, in_slot, sel_byte}),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data({out_frame_start, out_slot, out_byte})
    );
endmodule
`default_nettype wire

// File: rtl/tsoi_defines.vh
// Constants for the transmit section overhead insertion control block.
// Included by the control module and the bench, not by the buffer; holds definitions only.
`ifndef TSOI_DEFINES_VH
`define TSOI_DEFINES_VH
// Register indices; byte address is four times the index
`define TSOI_IDX_OP2 10'h01a
`define TSOI_IDX_K2 10'h038
`define TSOI_IDX_OP1 10'h030
`define TSOI_IDX_SRC1 10'h060
`define TSOI_IDX_SRC2 10'h061
`define TSOI_IDX_CFG 10'h070
`define TSOI_IDX_STAT 10'h071
`define TSOI_IDX_NAT 10'h072
`define TSOI_IDX_TRACE 10'h073
// Field positions
`define TSOI_OP1_AIS 7
`define TSOI_OP1_REI 6
`define TSOI_OP1_NAT 5
`define TSOI_OP1_RDI 4
`define TSOI_SRC1_E1 5
`define TSOI_SRC1_F1 4
`define TSOI_SRC1_D13 3
`define TSOI_SRC1_D412 2
`define TSOI_SRC1_E2 1
`define TSOI_SRC1_M1 0
`define TSOI_SRC2_K2 1
`define TSOI_OP2_EXC 2
`define TSOI_OP2_FRC 1
`define TSOI_CFG_REGEN 0
`define TSOI_CFG_NATSER 1
// Reset values and fixed codes
`define TSOI_RST_BYTE 8'h00
`define TSOI_NAT_DEFAULT 8'hAA
`define TSOI_AIS_BYTE 8'hFF
`define TSOI_RDI_CODE 3'b110
`define TSOI_RDI_NONE 3'b000
`define TSOI_RESP_OKAY 2'b00
`define TSOI_RESP_SLVERR 2'b10
// Overhead slot codes on the byte stream
`define TSOI_SLOT_J0 4'h0
`define TSOI_SLOT_E1 4'h1
`define TSOI_SLOT_F1 4'h2
`define TSOI_SLOT_D13 4'h3
`define TSOI_SLOT_D412 4'h4
`define TSOI_SLOT_E2 4'h5
`define TSOI_SLOT_M1 4'h6
`define TSOI_SLOT_K2 4'h7
`define TSOI_SLOT_NAT 4'h8
`define TSOI_SLOT_B1 4'h9
`define TSOI_SLOT_B2 4'hA
`define TSOI_SLOT_PTR 4'hB
`define TSOI_SLOT_PAY 4'hC
`endif

// File: rtl/tsoi_buffer.v
// Small FIFO with valid/ready on both sides for the outgoing byte stream.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tsoi_buffer #(
    parameter WIDTH = 13,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire aclk,
    input wire aresetn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    // Full and empty come straight from the occupancy count
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_reg[rd_ptr_reg];
    // Storage, one flip-flop row per entry
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
            always @(posedge aclk) begin
                if (!aresetn) begin
                    mem_reg[i] <= {WIDTH{1'b0}};
                end else if (push && wr_ptr_reg == i[AW-1:0]) begin
                    mem_reg[i] <= in_data;
                end
            end
        end
    endgenerate
    // Pointers wrap at DEPTH, which need not be a power of two
    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/tsoi_ctrl_checker.sv
// Checker for the overhead insertion control: bus and stream handshakes.
// Assumes it is bound to tsoi_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tsoi_ctrl_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [3:0] out_slot,
    input wire logic [7:0] out_byte
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [1:0] fill_reg;
    logic [1:0] fill_next;
    // Own count of buffered beats, so fullness is judged independently
    assign fill_next = fill_reg + {1'b0, in_valid & in_ready} - {1'b0, out_valid & out_ready};
    always @(posedge aclk) begin
        if (!aresetn) fill_reg <= 2'd0;
        else fill_reg <= fill_next;
    end
    // Reset must empty both answer channels and the stream
    reset_clears_a: assert property (disable iff (1'b0) !aresetn |=>
        !s_axi_bvalid && !s_axi_rvalid && !out_valid) else $error("state kept over reset");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    read_format_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000 &&
        s_axi_rresp[0] == 1'b0) else $error("bad read word");
    stream_hold_a: assert property (out_valid && !out_ready |=> out_valid &&
        $stable(out_byte) && $stable(out_slot)) else $error("beat changed during stall");
    stream_latency_a: assert property (in_valid && in_ready |=> out_valid)
        else $error("beat not offered after take");
    fill_level_a: assert property (in_ready == (fill_reg != 2'd2) &&
        out_valid == (fill_reg != 2'd0)) else $error("buffer flags disagree with fill");
endmodule
bind tsoi_ctrl tsoi_ctrl_checker i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_slot(out_slot), .out_byte(out_byte));
`default_nettype wire

// File: dv/tsoi_far_model.sv
// Far-side model: channel and serial overhead byte sources and the sink.
// Assumes the bench drives stall after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module tsoi_far_model (
    input wire logic stall,
    output logic out_ready,
    output logic [7:0] ser,
    output logic [47:0] chan
);
    // Distinct bytes per source so a wrong selection is visible
    assign ser = 8'h51;
    assign chan = 48'h5253_5455_5657;
    // Sink stalls only on request, ready otherwise
    assign out_ready = !stall;
endmodule
`default_nettype wire

// File: dv/tx_section_overhead_insert_ctrl_test.sv
// Self-checking bench for the overhead insertion control block.
// Assumes the far-side model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "tsoi_defines.vh"
module tx_section_overhead_insert_ctrl_test;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic in_valid = 1'b0, fs = 1'b0, excess = 1'b0, stall = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF, slot = 4'h0;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] out_slot;
    wire [7:0] out_byte, ser;
    wire [47:0] chan;
    wire awready, wready, bvalid, arready, rvalid, in_ready, out_valid, out_ready, out_fs;
    int fail_count = 0, num_checks = 0;
    // Rows in hex digits iiivvsee: register index, value, slot, expected byte
    logic [31:0] rows [38] = '{
        32'h0735_A05A, 32'h0604_0051, 32'h060C_00C3, 32'h0600_0152, 32'h0600_0253,
        32'h0600_0354, 32'h0600_0455, 32'h0600_0556, 32'h0600_0657, 32'h0603_E1C3,
        32'h0603_E2C3, 32'h0603_E3C3, 32'h0603_E4C3, 32'h0603_E5C3, 32'h0600_1651,
        32'h0600_0657, 32'h0304_0600, 32'h0300_08AA, 32'h0727_78AA, 32'h0302_0877,
        32'h038F_57F0, 32'h01A0_27F6, 32'h0301_07F5, 32'h0300_07F6, 32'h0610_2751,
        32'h0610_07F6, 32'h01A0_47F0, 32'h0300_29C3, 32'h0300_193C, 32'h0300_8AC3,
        32'h0300_4A3C, 32'h0308_0BFF, 32'h0308_0CFF, 32'h0308_093C, 32'h0700_16C3,
        32'h0700_17C3, 32'h0700_2851, 32'h0700_08AA};

    tsoi_far_model i_far (.stall(stall), .out_ready(out_ready), .ser(ser), .chan(chan));
    tsoi_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .in_valid(in_valid), .in_ready(in_ready), .in_slot(slot), .in_frame_start(fs),
        .in_gen_byte(8'h3C), .in_rx_byte(8'hC3), .overhead_serial_input(ser),
        .regen_orderwire_input(chan[47:40]), .user_channel_input(chan[39:32]),
        .regen_data_channel_input(chan[31:24]), .mux_data_channel_input(chan[23:16]),
        .mux_orderwire_input(chan[15:8]), .ms_error_count(chan[7:0]),
        .excess_ms_parity_status(excess), .out_valid(out_valid), .out_ready(out_ready),
        .out_slot(out_slot), .out_frame_start(out_fs), .out_byte(out_byte));

    initial forever #5 aclk = ~aclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Response and ready are held high, so a sampled valid is a handshake
    task automatic wr(input logic [9:0] idx, input logic [7:0] v, input logic [3:0] st,
                      input logic [1:0] rs);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h00_0000, v};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk({30'h0, bresp}, {30'h0, rs});
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] v, input logic [1:0] rs);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        chk(rdata, {24'h00_0000, v});
        chk({30'h0, rresp}, {30'h0, rs});
    endtask

    task automatic put(input logic [3:0] s, input logic f);
        slot <= s;
        fs <= f;
        in_valid <= 1'b1;
        do @(posedge aclk); while (!in_ready);
        in_valid <= 1'b0;
    endtask

    // Frame mark, slot and byte are compared together
    task automatic get(input logic [12:0] e);
        do @(posedge aclk); while (!(out_valid && out_ready));
        chk({19'h0, out_fs, out_slot, out_byte}, {19'h0, e});
    endtask

    task automatic xfer(input logic [3:0] s, input logic f, input logic [7:0] e);
        put(s, f);
        get({f, s, e});
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`TSOI_IDX_OP1, 8'h00, `TSOI_RESP_OKAY);
        // Table walk over every byte source and mode, with parity codes 01 and 10
        for (int i = 0; i < 38; i++) begin
            wr(rows[i][29:20], rows[i][19:12], 4'hF, `TSOI_RESP_OKAY);
            xfer(rows[i][11:8], 1'b0, rows[i][7:0]);
        end
        // Excess parity status drives RDI only with hardware RDI bits
        wr(`TSOI_IDX_OP1, 8'h00, 4'hF, `TSOI_RESP_OKAY);
        excess <= 1'b1;
        xfer(4'h7, 1'b0, 8'hF6);
        rd(`TSOI_IDX_STAT, 8'h09, `TSOI_RESP_OKAY);
        wr(`TSOI_IDX_OP1, 8'h10, 4'hF, `TSOI_RESP_OKAY);
        xfer(4'h7, 1'b0, 8'hF5);
        wr(`TSOI_IDX_OP1, 8'h00, 4'hF, `TSOI_RESP_OKAY);
        excess <= 1'b0;
        xfer(4'h7, 1'b0, 8'hF0);
        // Single-frame code inverts both parity bytes of one frame only
        wr(`TSOI_IDX_OP1, 8'h0F, 4'hF, `TSOI_RESP_OKAY);
        rd(`TSOI_IDX_STAT, 8'h06, `TSOI_RESP_OKAY);
        xfer(4'h9, 1'b1, 8'hC3);
        xfer(4'hA, 1'b0, 8'hC3);
        xfer(4'h9, 1'b1, 8'h3C);
        xfer(4'hA, 1'b0, 8'h3C);
        // Sink stalls: two beats fill the buffer, then nothing is lost
        stall <= 1'b1;
        put(4'h1, 1'b0);
        @(posedge aclk);
        put(4'h2, 1'b0);
        @(posedge aclk);
        chk({31'h0, in_ready}, 32'h0000_0000);
        stall <= 1'b0;
        get(13'h0152);
        get(13'h0253);
        @(posedge aclk);
        chk({31'h0, out_valid}, 32'h0000_0000);
        // Refused and partial writes leave the registers alone
        wr(10'h005, 8'h11, 4'hF, `TSOI_RESP_SLVERR);
        rd(10'h005, 8'h00, `TSOI_RESP_SLVERR);
        wr(`TSOI_IDX_STAT, 8'h11, 4'hF, `TSOI_RESP_SLVERR);
        wr(`TSOI_IDX_OP2, 8'h06, 4'h0, `TSOI_RESP_OKAY);
        rd(`TSOI_IDX_OP2, 8'h04, `TSOI_RESP_OKAY);
        rd(`TSOI_IDX_OP1, 8'h0F, `TSOI_RESP_OKAY);
        // Reset in mid-run returns the documented registers to zero
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`TSOI_IDX_OP1, 8'h00, `TSOI_RESP_OKAY);
        rd(`TSOI_IDX_OP2, 8'h00, `TSOI_RESP_OKAY);
        rd(`TSOI_IDX_SRC1, 8'h00, `TSOI_RESP_OKAY);
        end_of_test();
    end
endmodule
`default_nettype wire
